// *** hdl/irm_pkg.sv ***
// Purpose: shared constants and carriers for the internal ram mapper
// Assumes: 1 Mbyte space, 32 Kbyte ram window
// Notes:   bus states t1..t4 come from the cpu bus unit
package irm_pkg;
    localparam int          ADDR_W      = 20;
    localparam int          BASE_W      = 5;
    localparam int          BASE_LSB    = 15;
    localparam int          RAM_BYTES   = 32768;
    localparam int          WORDS16     = 16384;
    localparam int          WORDS8      = 32768;
    localparam logic [4:0]  BASE_RST    = 5'h00;
    localparam logic        EN_RST      = 1'b0;
    localparam logic        SR_RST      = 1'b0;
    localparam int          WAIT_STATES = 0;

    typedef enum logic [1:0] {
        irm_t1,
        irm_t2,
        irm_t3,
        irm_t4
    } irm_tstate_t;

    // one bus cycle request from the cpu bus unit
    typedef struct packed {
        logic                valid;
        logic                wr;
        logic                byte_acc;
        logic [ADDR_W-1:0]   addr;
        logic [15:0]         wdata;
    } irm_req_t;

    // ram window map register image
    typedef struct packed {
        logic                en;
        logic                show_read_bit;
        logic [BASE_W-1:0]   ram_base_field;
    } irm_map_t;
endpackage

// *** hdl/irm_ram_mapper.sv ***
// Purpose: on-chip 32 Kbyte ram with window mapping, overlap and debug modes
// Assumes: request held for t1..t4 of one zero-wait bus cycle
// Notes:   straps sampled by the clock after reset release
//
// How it works
// - 32 Kbyte ram, 16K x 16 in wide variant, zero-wait timing
// - narrow variant holds 32K x 8, zero-wait timing
// - window sits on any 32 Kbyte boundary of 1 Mbyte space
// - window base comes from five base bits, address bits 19..15
// - overlap asserts both selects, reads return internal ram data
// - overlapped writes hit ram and run full external write cycle
// - internal accesses drive external read/write strobes and write data
// - disable strap low at reset sends window accesses external
// - show-read drives full 16-bit muxed bus, both lanes on byte reads
// - show-read from strap low or bit; either one turns it on
// - shown read: address in t1,t2, data in t3,t4
// - normal reads leave muxed bus floating in t2,t3,t4
`timescale 1ns/10ps
`default_nettype none
module irm_ram_mapper
    import irm_pkg::*;
#(
    parameter bit WIDE = 1'b1
) (
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire irm_req_t            req,
    input  wire irm_tstate_t         tstate,
    input  wire irm_map_t            map_wr,
    input  wire logic                map_we,
    input  wire logic                ext_cs_hit,
    input  wire logic                ram_disable_strap_n,
    input  wire logic                show_read_strap_n,
    output logic [15:0]              rdata,
    output logic                     int_sel,
    output logic                     ext_sel,
    output logic                     rd_strobe_n,
    output logic                     wr_strobe_n,
    output logic [15:0]              muxed_addr_data_bus_o,
    output logic                     muxed_addr_data_bus_oe_n,
    output logic [ADDR_W-1:0]        flat_address_bus,
    output irm_map_t                 ram_window_map_register
);
    ////////////////////////////////////////////////////////////////////
    // ram array
    logic [7:0]   mem_lo [WORDS16];
    logic [7:0]   mem_hi [WORDS16];

    ////////////////////////////////////////////////////////////////////
    // strap synchronisers and capture
    logic [1:0]  dis_s_q, sr_s_q;
    logic [2:0]  cap_q, cap_d;
    logic        dis_q, dis_d, srs_q, srs_d;
    irm_map_t    map_q, map_d;

    function automatic logic in_window(input logic [ADDR_W-1:0] a, input irm_map_t m);
        return m.en && (a[ADDR_W-1:BASE_LSB] == m.ram_base_field);
    endfunction

    always_comb begin
        // straps taken once, third edge after release
        cap_d = {cap_q[1:0], 1'b1};
        dis_d = dis_q;
        srs_d = srs_q;
        if (cap_q == 3'h3) begin
            dis_d = ~dis_s_q[1];
            srs_d = ~sr_s_q[1];
        end
        map_d = map_we ? map_wr : map_q;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dis_s_q <= 2'h3;
            sr_s_q  <= 2'h3;
            cap_q   <= 3'h0;
            dis_q   <= 1'b0;
            srs_q   <= 1'b0;
            map_q   <= '{en: EN_RST, show_read_bit: SR_RST, ram_base_field: BASE_RST};
        end else begin
            dis_s_q <= {dis_s_q[0], ram_disable_strap_n};
            sr_s_q  <= {sr_s_q[0], show_read_strap_n};
            cap_q   <= cap_d;
            dis_q   <= dis_d;
            srs_q   <= srs_d;
            map_q   <= map_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bus cycle decode
    logic        hit, ram_act, show;
    logic [13:0] widx;
    logic [15:0] rword;
    logic [15:0] rdata_d, bus_d;
    logic        oe_n_d, rd_n_d, wr_n_d, isel_d, esel_d;

    assign hit     = req.valid && in_window(req.addr, map_q);
    assign ram_act = hit && !dis_q;
    assign show    = srs_q || map_q.show_read_bit;
    assign widx    = req.addr[14:1];
    assign rword   = WIDE ? {mem_hi[widx], mem_lo[widx]}
                          : {2{req.addr[0] ? mem_hi[widx] : mem_lo[widx]}};

    always_comb begin
        rdata_d = rdata;
        isel_d  = ram_act;
        esel_d  = ext_cs_hit || (hit && dis_q);
        rd_n_d  = ~(req.valid && !req.wr && tstate != irm_t1);
        wr_n_d  = ~(req.valid && req.wr && tstate != irm_t1);
        bus_d   = req.addr[15:0];
        oe_n_d  = 1'b1;
        if (req.valid) begin
            unique case (tstate)
                irm_t1: oe_n_d = 1'b0;
                irm_t2: oe_n_d = !(req.wr || (ram_act && show));
                irm_t3, irm_t4: begin
                    if (req.wr) begin
                        bus_d  = req.wdata;
                        oe_n_d = 1'b0;
                    end else if (ram_act && show) begin
                        bus_d  = rword;
                        oe_n_d = 1'b0;
                    end
                end
            endcase
        end
        if (ram_act && !req.wr && tstate == irm_t3) begin
            rdata_d = rword;
        end
    end

    always_ff @(posedge clk) begin
        if (ram_act && req.wr && tstate == irm_t3) begin
            if (WIDE ? (!req.byte_acc || !req.addr[0]) : !req.addr[0]) begin
                mem_lo[widx] <= req.wdata[7:0];
            end
            if (WIDE ? (!req.byte_acc || req.addr[0]) : req.addr[0]) begin
                mem_hi[widx] <= (WIDE && !req.byte_acc) ? req.wdata[15:8] : req.wdata[7:0];
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata                    <= 16'h0000;
            int_sel                  <= 1'b0;
            ext_sel                  <= 1'b0;
            rd_strobe_n              <= 1'b1;
            wr_strobe_n              <= 1'b1;
            muxed_addr_data_bus_o    <= 16'h0000;
            muxed_addr_data_bus_oe_n <= 1'b1;
            flat_address_bus         <= '0;
            ram_window_map_register  <= '0;
        end else begin
            rdata                    <= rdata_d;
            int_sel                  <= isel_d;
            ext_sel                  <= esel_d;
            rd_strobe_n              <= rd_n_d;
            wr_strobe_n              <= wr_n_d;
            muxed_addr_data_bus_o    <= bus_d;
            muxed_addr_data_bus_oe_n <= oe_n_d;
            flat_address_bus         <= req.addr;
            ram_window_map_register  <= map_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    map_base_a: assert property (@(posedge clk) disable iff (!nrst)
        req.valid && map_q.en && !dis_q && req.addr[19:15] == map_q.ram_base_field
        |=> int_sel) else $error("window hit not selected");
    both_sel_a: assert property (@(posedge clk) disable iff (!nrst)
        ram_act && ext_cs_hit |=> int_sel && ext_sel) else $error("overlap lost");
    wr_ext_a: assert property (@(posedge clk) disable iff (!nrst)
        req.valid && req.wr && tstate == irm_t2 |=> !wr_strobe_n) else $error("no wr");
    wr_data_a: assert property (@(posedge clk) disable iff (!nrst)
        req.valid && req.wr && tstate == irm_t3 |=> !muxed_addr_data_bus_oe_n
        && muxed_addr_data_bus_o == $past(req.wdata)) else $error("wr data");
    dis_ext_a: assert property (@(posedge clk) disable iff (!nrst)
        hit && dis_q |=> ext_sel && !int_sel) else $error("disable mode");
    show_dat_a: assert property (@(posedge clk) disable iff (!nrst)
        ram_act && show && !req.wr && tstate == irm_t4 |=> !muxed_addr_data_bus_oe_n
        && muxed_addr_data_bus_o == $past(rword)) else $error("show data");
    strap_win_a: assert property (@(posedge clk) disable iff (!nrst)
        srs_q && ram_act && !req.wr && tstate == irm_t3 |=> !muxed_addr_data_bus_oe_n)
        else $error("strap show");
    show_addr_a: assert property (@(posedge clk) disable iff (!nrst)
        req.valid && tstate == irm_t1 |=> !muxed_addr_data_bus_oe_n
        && muxed_addr_data_bus_o == $past(req.addr[15:0])) else $error("addr");
    float_rd_a: assert property (@(posedge clk) disable iff (!nrst)
        req.valid && !req.wr && !(ram_act && show) && tstate != irm_t1
        |=> muxed_addr_data_bus_oe_n) else $error("bus not floating");
    rd_int_a: assert property (@(posedge clk) disable iff (!nrst)
        ram_act && !req.wr && tstate == irm_t3 |=> rdata == $past(rword))
        else $error("read data");
    rd_strobe_a: assert property (@(posedge clk) disable iff (!nrst)
        req.valid && !req.wr && tstate != irm_t1 |=> !rd_strobe_n && wr_strobe_n)
        else $error("read strobe");
    flat_addr_a: assert property (@(posedge clk) disable iff (!nrst)
        req.valid |=> flat_address_bus == $past(req.addr)) else $error("flat address");
    map_copy_a: assert property (@(posedge clk) disable iff (!nrst)
        map_we |-> ##2 ram_window_map_register == $past(map_wr, 2)) else $error("map copy");
    ext_sel_a: assert property (@(posedge clk) disable iff (!nrst)
        req.valid && ext_cs_hit |=> ext_sel) else $error("external select");
    strap_cap_a: assert property (@(posedge clk) disable iff (!nrst)
        cap_q == 3'h3 |=> dis_q == !$past(dis_s_q[1]) && srs_q == !$past(sr_s_q[1]))
        else $error("strap capture");

    ////////////////////////////////////////////////////////////////////
    // scenario covers
    show_rd_c: cover property (@(posedge clk) disable iff (!nrst)
        ram_act && show && !req.wr && tstate == irm_t4);
    ovl_wr_c: cover property (@(posedge clk) disable iff (!nrst)
        ram_act && ext_cs_hit && req.wr);
    dis_c: cover property (@(posedge clk) disable iff (!nrst) hit && dis_q);
    strap_show_c: cover property (@(posedge clk) disable iff (!nrst)
        srs_q && ram_act && !req.wr && tstate == irm_t3);
endmodule // irm_ram_mapper
`default_nettype wire

// *** tb/irm_ext_bus_model.sv ***
// Purpose: far-side bus watcher
// Assumes: zero waits, ready ignored
// Notes:   keeps last visible write
`timescale 1ns/10ps
`default_nettype none
module irm_ext_bus_model (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        wr_n,
    input  wire logic [15:0] bus_o,
    input  wire logic        oe_n,
    output logic [15:0]      bus,
    output logic [15:0]      last_wr
);
    logic [15:0] hold_q;
    // never drives, floating bus toggles
    assign bus = oe_n ? ~hold_q : bus_o;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hold_q <= 16'h0000;
            last_wr <= 16'h0000;
        end else begin
            hold_q <= bus;
            if (!wr_n) begin
                last_wr <= bus;
            end
        end
    end
endmodule // irm_ext_bus_model
`default_nettype wire

// *** tb/irm_ram_mapper_tb.sv ***
// Purpose: self-checking bench for irm_ram_mapper
// Assumes: wide variant, inputs on falling edge
// Notes:   mem holds expected ram words
`timescale 1ns/10ps
`default_nettype none
module irm_ram_mapper_tb;
    import irm_pkg::*;
    logic        clk, nrst, map_we, ext_cs_hit, dis_n, shw_n, int_sel, ext_sel, rd_n, wr_n, oe_n;
    logic [15:0] rdata, bus_o, bus, last_wr, lf, d;
    logic [15:0] mem [0:WORDS16-1];
    logic [19:0] flat;
    logic [13:0] off;
    logic [4:0]  base;
    irm_req_t    req;
    irm_tstate_t tstate;
    irm_map_t    map_wr, map_q;
    int          err_total, compares, cycles;

    irm_ram_mapper irm_ram_mapper_i (.clk(clk), .nrst(nrst), .req(req), .tstate(tstate),
        .map_wr(map_wr), .map_we(map_we), .ext_cs_hit(ext_cs_hit), .rdata(rdata),
        .ram_disable_strap_n(dis_n), .show_read_strap_n(shw_n), .int_sel(int_sel),
        .ext_sel(ext_sel), .rd_strobe_n(rd_n), .wr_strobe_n(wr_n), .muxed_addr_data_bus_o(bus_o),
        .muxed_addr_data_bus_oe_n(oe_n), .flat_address_bus(flat), .ram_window_map_register(map_q));
    irm_ext_bus_model irm_ext_bus_model_i (.clk(clk), .nrst(nrst), .wr_n(wr_n), .bus_o(bus_o),
        .oe_n(oe_n), .bus(bus), .last_wr(last_wr));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_total++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic chk(input logic [19:0] got, input logic [19:0] want);
        compares++;
        if (got !== want) begin
            err_total++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic results();
        if (err_total == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic rst(input logic dn, input logic sn);
        @(negedge clk);
        nrst = 1'b0;
        dis_n = dn;
        shw_n = sn;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
    endtask
    task automatic map(input logic sr);
        @(negedge clk);
        map_wr = '{1'b1, sr, base};
        map_we = 1'b1;
        @(negedge clk);
        map_we = 1'b0;
        @(negedge clk);
        chk(20'(map_q), 20'(map_wr));
    endtask
    task automatic cyc(input logic wr, bt, input logic [19:0] a, input logic sh, hit, ext);
        logic [15:0] w;
        logic        v;
        w = wr ? d : mem[a[14:1]];
        v = wr | sh;
        @(negedge clk);
        req = '{1'b1, wr, bt, a, d};
        for (int i = 0; i < 4; i++) begin
            tstate = irm_tstate_t'(i);
            @(negedge clk);
            if (i == 0) begin
                chk(flat, a);
                chk(20'({oe_n, bus}), 20'({1'b0, a[15:0]}));
            end else if (i == 1) begin
                chk(20'({ext_sel, int_sel, rd_n, wr_n}), 20'({ext, hit, wr, ~wr}));
                if (!wr) chk({3'h0, oe_n, sh ? bus : 16'h0}, {3'h0, ~sh, sh ? a[15:0] : 16'h0});
            end else begin
                chk({3'h0, oe_n, v ? bus : 16'h0}, {3'h0, ~v, v ? w : 16'h0});
                if (i == 2 && !wr && hit) chk(20'(rdata), 20'(w));
            end
        end
        req.valid = 1'b0;
        if (wr) chk(20'(last_wr), 20'(d));
        if (wr && hit) mem[a[14:1]] = d;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {nrst, map_we, ext_cs_hit, dis_n, shw_n} = 5'h03;
        {map_wr, req, lf, base, d} = '0;
        tstate = irm_t1;
        lf = 16'h2D83;
        rst(1'b1, 1'b1);
        cyc(1'b0, 1'b0, 20'h00020, 1'b0, 1'b0, 1'b0);
        lf = nxt(lf);
        base = lf[4:0];
        for (int k = 0; k < 8; k++) begin
            lf = nxt(lf);
            d = lf;
            off = (k == 0) ? 14'h0000 : (k == 1) ? 14'h3FFF : lf[15:2];
            map(lf[1]);
            ext_cs_hit = lf[0];
            cyc(1'b1, 1'b0, {base, off, 1'b0}, 1'b0, 1'b1, lf[0]);
            cyc(1'b0, 1'b0, {base, off, 1'b0}, lf[1], 1'b1, lf[0]);
        end
        ext_cs_hit = 1'b0;
        map(1'b1);
        cyc(1'b0, 1'b1, {base, off, 1'b1}, 1'b1, 1'b1, 1'b0);
        cyc(1'b0, 1'b0, {base ^ 5'h01, off, 1'b0}, 1'b0, 1'b0, 1'b0);
        rst(1'b0, 1'b1);
        map(1'b0);
        d = ~d;
        cyc(1'b1, 1'b0, {base, off, 1'b0}, 1'b0, 1'b0, 1'b1);
        cyc(1'b0, 1'b0, {base, off, 1'b0}, 1'b0, 1'b0, 1'b1);
        rst(1'b1, 1'b0);
        map(1'b0);
        cyc(1'b0, 1'b0, {base, off, 1'b0}, 1'b1, 1'b1, 1'b0);
        d = nxt(lf);
        cyc(1'b1, 1'b0, {base, off, 1'b0}, 1'b0, 1'b1, 1'b0);
        cyc(1'b0, 1'b0, {base, off, 1'b0}, 1'b1, 1'b1, 1'b0);
        results();
    end
endmodule // irm_ram_mapper_tb
`default_nettype wire
